// ---- hdl/msd_pkg.sv ----
// Package for the multiplier, shifter and status datapath slice.
// Assumes one CPU clock and a decoder that issues one-cycle operation codes.
package msd_pkg;
  localparam int DATA_W = 16;
  localparam int PROD_W = 32;
  localparam int IMM_W = 13;
  localparam int SHAMT_W = 5;
  localparam logic [SHAMT_W-1:0] MAX_SHIFT = 5'h10;

  // --------------------------------------------------------------------
  // Reset values of the status bits
  // --------------------------------------------------------------------
  localparam logic RST_EXCESS = 1'h0;
  localparam logic RST_SATURATE = 1'h0;
  localparam logic [1:0] RST_SCALE = 2'h0;
  localparam logic RST_SIGN_EXT = 1'h1;
  localparam logic RST_TEST = 1'h0;
  localparam logic RST_GEN_OUT = 1'h1;

  // --------------------------------------------------------------------
  // Field positions in the status load word
  // --------------------------------------------------------------------
  localparam int ST_EXCESS_BIT = 12;
  localparam int ST_SATURATE_BIT = 11;
  localparam int ST_TEST_BIT = 10;
  localparam int ST_SIGN_EXT_BIT = 9;
  localparam int ST_GEN_OUT_BIT = 4;
  localparam int ST_SCALE_LSB = 0;

  // Product scale shift distances
  localparam int SCALE_LEFT_SMALL = 1;
  localparam int SCALE_LEFT_LARGE = 4;
  localparam int SCALE_RIGHT = 6;

  localparam logic [PROD_W-1:0] POS_LIMIT = 32'h7fffffff;
  localparam logic [PROD_W-1:0] NEG_LIMIT = 32'h80000000;

  // Cycles between products with the short immediate operand
  localparam int IMM_PRODUCT_CYCLES = 2;

  typedef enum logic [1:0] {
    MSD_SCALE_NONE,
    MSD_SCALE_LEFT1,
    MSD_SCALE_LEFT4,
    MSD_SCALE_RIGHT6
  } msd_scale_t;

  // Multiplier operations issued by the decoder
  typedef enum logic [3:0] {
    MSD_OP_NONE,
    MSD_OP_LOAD_OPERAND,
    MSD_OP_LOAD_MOVE_PROD,
    MSD_OP_LOAD_ADD_PROD,
    MSD_OP_LOAD_ADD_PROD_MOVE,
    MSD_OP_LOAD_SUB_PROD,
    MSD_OP_MPY,
    MSD_OP_MPY_IMM,
    MSD_OP_UNSIGNED_MULTIPLY_OP,
    MSD_OP_MAC,
    MSD_OP_MAC_SHIFT,
    MSD_OP_SQUARE_ADD,
    MSD_OP_SQUARE_SUB
  } msd_mop_t;

  // Product actions requested of the ALU
  typedef enum logic [1:0] {
    MSD_ALU_NONE,
    MSD_ALU_LOAD,
    MSD_ALU_ADD,
    MSD_ALU_SUB
  } msd_alu_t;

  // Status bits that set-bit and clear-bit can address
  typedef enum logic [2:0] {
    MSD_BIT_SATURATE,
    MSD_BIT_SIGN_EXT,
    MSD_BIT_GEN_OUT,
    MSD_BIT_OTHER
  } msd_bit_t;
endpackage : msd_pkg

// ---- hdl/msd_scaler.sv ----
// Input scaling shifter: 16-bit bus data to a 32-bit ALU operand.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module msd_scaler (
  // Data
  input wire logic [msd_pkg::DATA_W-1:0] data_in,
  input wire logic [msd_pkg::SHAMT_W-1:0] shift_amt,
  input wire logic extend,
  output logic [msd_pkg::PROD_W-1:0] data_out
);
  import msd_pkg::*;

  logic [PROD_W-1:0] widened;
  logic [SHAMT_W-1:0] amt;

  always_comb begin
    widened = {{DATA_W{extend & data_in[DATA_W-1]}}, data_in};
    // Counts above sixteen are clamped rather than wrapping
    amt = (shift_amt > MAX_SHIFT) ? MAX_SHIFT : shift_amt;
    data_out = widened << amt;
  end
endmodule : msd_scaler

// ---- hdl/msd_datapath.sv ----
// Multiplier, product scaling, input scaling and status bits of the CPU slice.
// Assumes the decoder issues one-cycle operation strobes and supplies the
// addresses, memory reads and accumulator value; all signals share ref_clk.
//
// Behaviour
// - Excess flag sticks until branch, load, reset
// - Saturate select chooses wrap or clamp
// - Scale select picks none, left1, left4, right6
// - Shift only outgoing product, store unchanged
// - Scale select reset clear; scale/status load
// - Sign-extend select extends; unextended add never
// - Sign-extend reset one; set, clear, load
// - Test flag from bit, compare, normalize
// - General output flag drives pin, resets one
// - Scaler shifts 0..16, fills zeros or sign
// - Shift count from instruction or operand
// - One cycle product, signed except unsigned op
// - 16-bit operand, 32-bit product registers
// - Short immediate multiply, product every two
// - Operand load with parallel product action
// - Multiply-accumulate fetches both operands each cycle
// - Data-shift variant moves sample forward
// - Unsigned multiply of operand and memory
// - Square ops feed one value twice
// - Product stores pass through scale shifter
// - Saturation loads positive or negative limit
`timescale 1ns/10ps
module msd_datapath (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Multiplier control and operands
  input wire msd_pkg::msd_mop_t mult_op,
  input wire logic [msd_pkg::DATA_W-1:0] data_bus,
  input wire logic [msd_pkg::DATA_W-1:0] prog_bus,
  input wire logic [msd_pkg::IMM_W-1:0] imm_operand,
  // Input scaling shifter request
  input wire logic scale_in_req,
  input wire logic [msd_pkg::DATA_W-1:0] scale_in_data,
  input wire logic [msd_pkg::SHAMT_W-1:0] scale_in_const,
  input wire logic scale_by_operand,
  input wire logic add_unextended_op,
  // Accumulator write-back from the ALU
  input wire logic alu_write,
  input wire logic alu_arith,
  input wire logic alu_is_sub,
  input wire logic [msd_pkg::PROD_W-1:0] alu_a,
  input wire logic [msd_pkg::PROD_W-1:0] alu_b,
  input wire logic [msd_pkg::PROD_W-1:0] alu_logic_result,
  // Status instructions
  input wire logic set_flag_op,
  input wire logic clear_flag_op,
  input wire msd_pkg::msd_bit_t flag_sel,
  input wire logic set_product_scale_op,
  input wire logic [1:0] scale_value,
  input wire logic load_status_op,
  input wire logic [msd_pkg::DATA_W-1:0] status_word_one,
  input wire logic conditional_branch_op,
  input wire logic branch_tests_excess,
  // Test sources
  input wire logic indexed_position_test_op,
  input wire logic tested_bit,
  input wire logic aux_compare_op,
  input wire logic aux_compare_true,
  input wire logic exponent_align_op,
  input wire logic [1:0] acc_top_bits,
  // Product stores
  input wire logic store_product_upper,
  input wire logic store_product_lower,
  // Outputs to the ALU and memory
  output logic [msd_pkg::PROD_W-1:0] product_to_alu,
  output msd_pkg::msd_alu_t product_alu_action,
  output logic [msd_pkg::PROD_W-1:0] scaled_operand,
  output logic [msd_pkg::PROD_W-1:0] acc_result,
  output logic acc_result_valid,
  output logic [msd_pkg::DATA_W-1:0] store_data,
  output logic store_valid,
  output logic data_move_req,
  output logic fetch_both_req,
  output logic product_ready,
  output logic [msd_pkg::DATA_W-1:0] mult_operand_out,
  output logic [msd_pkg::PROD_W-1:0] product_out,
  // Status
  output logic latched_arith_excess_flag,
  output logic saturate_select,
  output msd_pkg::msd_scale_t product_scale_select,
  output logic sign_extend_select,
  output logic test_result_flag,
  output logic general_output_flag
);
  import msd_pkg::*;

  // ------------------------------------------------------------------
  // Product output shifter
  // ------------------------------------------------------------------
  function automatic logic [PROD_W-1:0] scale_product(input logic [PROD_W-1:0] p, input msd_scale_t s);
    unique case (s)
      MSD_SCALE_NONE: scale_product = p;
      MSD_SCALE_LEFT1: scale_product = p << SCALE_LEFT_SMALL;
      MSD_SCALE_LEFT4: scale_product = p << SCALE_LEFT_LARGE;
      MSD_SCALE_RIGHT6: scale_product = PROD_W'($signed(p) >>> SCALE_RIGHT);
    endcase
  endfunction : scale_product

  // ------------------------------------------------------------------
  // Multiplier state
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] mult_operand_reg;
  logic [PROD_W-1:0] product_reg;
  logic imm_busy;
  logic [DATA_W-1:0] next_mult_operand_reg;
  logic [PROD_W-1:0] next_product_reg;
  logic next_imm_busy;
  logic [DATA_W-1:0] mul_a;
  logic [DATA_W-1:0] mul_b;
  logic mul_signed;
  logic do_mult;
  logic [PROD_W-1:0] mul_result;
  logic [PROD_W-1:0] scaled_product;
  msd_alu_t next_alu_action;

  always_comb begin
    next_mult_operand_reg = mult_operand_reg;
    next_product_reg = product_reg;
    next_imm_busy = 1'h0;
    next_alu_action = MSD_ALU_NONE;
    mul_a = mult_operand_reg;
    mul_b = data_bus;
    mul_signed = 1'h1;
    do_mult = 1'h0;
    unique case (mult_op)
      MSD_OP_LOAD_OPERAND: next_mult_operand_reg = data_bus;
      MSD_OP_LOAD_MOVE_PROD: begin
        next_mult_operand_reg = data_bus;
        next_alu_action = MSD_ALU_LOAD;
      end
      MSD_OP_LOAD_ADD_PROD, MSD_OP_LOAD_ADD_PROD_MOVE: begin
        next_mult_operand_reg = data_bus;
        next_alu_action = MSD_ALU_ADD;
      end
      MSD_OP_LOAD_SUB_PROD: begin
        next_mult_operand_reg = data_bus;
        next_alu_action = MSD_ALU_SUB;
      end
      MSD_OP_MPY: do_mult = 1'h1;
      MSD_OP_MPY_IMM: begin
        // Short immediate, sign-extended; product_ready flags the result two cycles later
        mul_b = {{(DATA_W-IMM_W){imm_operand[IMM_W-1]}}, imm_operand};
        do_mult = 1'h1;
        next_imm_busy = 1'h1;
      end
      MSD_OP_UNSIGNED_MULTIPLY_OP: begin
        mul_signed = 1'h0;
        do_mult = 1'h1;
      end
      MSD_OP_MAC, MSD_OP_MAC_SHIFT: begin
        // Previous product accumulates while the new pair multiplies
        mul_b = prog_bus;
        next_mult_operand_reg = data_bus;
        mul_a = data_bus;
        do_mult = 1'h1;
        next_alu_action = MSD_ALU_ADD;
      end
      MSD_OP_SQUARE_ADD, MSD_OP_SQUARE_SUB: begin
        mul_a = data_bus;
        mul_b = data_bus;
        next_mult_operand_reg = data_bus;
        do_mult = 1'h1;
        next_alu_action = (mult_op == MSD_OP_SQUARE_ADD) ? MSD_ALU_ADD : MSD_ALU_SUB;
      end
      default: ;
    endcase
    if (mul_signed) begin
      mul_result = PROD_W'($signed(mul_a) * $signed(mul_b));
    end else begin
      mul_result = PROD_W'(mul_a * mul_b);
    end
    if (do_mult) begin
      next_product_reg = mul_result;
    end
    // Shift only on the way out, the stored product stays as computed
    scaled_product = scale_product(product_reg, product_scale_select);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mult_operand_reg <= '0;
      product_reg <= '0;
      imm_busy <= 1'h0;
      product_to_alu <= '0;
      product_alu_action <= MSD_ALU_NONE;
      data_move_req <= 1'h0;
      fetch_both_req <= 1'h0;
      product_ready <= 1'h0;
      store_data <= '0;
      store_valid <= 1'h0;
    end else begin
      mult_operand_reg <= next_mult_operand_reg;
      product_reg <= next_product_reg;
      imm_busy <= next_imm_busy;
      product_to_alu <= scaled_product;
      product_alu_action <= next_alu_action;
      data_move_req <= (mult_op == MSD_OP_MAC_SHIFT) || (mult_op == MSD_OP_LOAD_ADD_PROD_MOVE);
      fetch_both_req <= (mult_op == MSD_OP_MAC) || (mult_op == MSD_OP_MAC_SHIFT);
      product_ready <= do_mult & ~next_imm_busy | imm_busy;
      store_valid <= store_product_upper | store_product_lower;
      store_data <= store_product_upper ? scaled_product[PROD_W-1:DATA_W] : scaled_product[DATA_W-1:0];
    end
  end

  assign mult_operand_out = mult_operand_reg;
  assign product_out = product_reg;

  // ------------------------------------------------------------------
  // Input scaling shifter
  // ------------------------------------------------------------------
  logic [SHAMT_W-1:0] scale_amt;
  logic [PROD_W-1:0] scaler_out;
  logic scale_extend;

  always_comb begin
    // Operand register low bits give the dynamic count
    scale_amt = scale_by_operand ? {1'h0, mult_operand_reg[3:0]} : scale_in_const;
    scale_extend = sign_extend_select & ~add_unextended_op;
  end

  msd_scaler u_scaler (
    .data_in(scale_in_data),
    .shift_amt(scale_amt),
    .extend(scale_extend),
    .data_out(scaler_out)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scaled_operand <= '0;
    end else if (scale_in_req) begin
      scaled_operand <= scaler_out;
    end
  end

  // ------------------------------------------------------------------
  // Accumulator result with overflow handling
  // ------------------------------------------------------------------
  logic [PROD_W-1:0] sum;
  logic arith_excess;
  logic [PROD_W-1:0] next_acc;

  always_comb begin
    sum = alu_is_sub ? alu_a - alu_b : alu_a + alu_b;
    // Overflow when operand signs imply one sign and the result shows the other
    arith_excess = alu_write & alu_arith &
      ((alu_a[PROD_W-1] ^ sum[PROD_W-1]) & ((alu_a[PROD_W-1] ^ alu_b[PROD_W-1]) ~^ alu_is_sub));
    if (!alu_arith) begin
      next_acc = alu_logic_result;
    end else if (arith_excess && saturate_select) begin
      next_acc = alu_a[PROD_W-1] ? NEG_LIMIT : POS_LIMIT;
    end else begin
      next_acc = sum;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc_result <= '0;
      acc_result_valid <= 1'h0;
    end else begin
      acc_result <= alu_write ? next_acc : acc_result;
      acc_result_valid <= alu_write;
    end
  end

  // ------------------------------------------------------------------
  // Status bits
  // ------------------------------------------------------------------
  logic next_excess;
  logic next_saturate;
  msd_scale_t next_scale;
  logic next_sign_ext;
  logic next_test;
  logic next_gen_out;

  always_comb begin
    next_excess = latched_arith_excess_flag;
    next_saturate = saturate_select;
    next_scale = product_scale_select;
    next_sign_ext = sign_extend_select;
    next_test = test_result_flag;
    next_gen_out = general_output_flag;
    if (load_status_op) begin
      next_excess = status_word_one[ST_EXCESS_BIT];
      next_saturate = status_word_one[ST_SATURATE_BIT];
      next_scale = msd_scale_t'(status_word_one[ST_SCALE_LSB +: 2]);
      next_sign_ext = status_word_one[ST_SIGN_EXT_BIT];
      next_test = status_word_one[ST_TEST_BIT];
      next_gen_out = status_word_one[ST_GEN_OUT_BIT];
    end
    if (conditional_branch_op && branch_tests_excess) begin
      next_excess = 1'h0;
    end
    if (set_flag_op || clear_flag_op) begin
      unique case (flag_sel)
        MSD_BIT_SATURATE: next_saturate = set_flag_op;
        MSD_BIT_SIGN_EXT: next_sign_ext = set_flag_op;
        MSD_BIT_GEN_OUT: next_gen_out = set_flag_op;
        default: ;
      endcase
    end
    if (set_product_scale_op) begin
      next_scale = msd_scale_t'(scale_value);
    end
    if (indexed_position_test_op) begin
      next_test = tested_bit;
    end else if (aux_compare_op) begin
      next_test = aux_compare_true;
    end else if (exponent_align_op) begin
      next_test = acc_top_bits[1] ^ acc_top_bits[0];
    end
    // A new overflow wins over any clear in the same cycle
    if (arith_excess) begin
      next_excess = 1'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latched_arith_excess_flag <= RST_EXCESS;
      saturate_select <= RST_SATURATE;
      product_scale_select <= msd_scale_t'(RST_SCALE);
      sign_extend_select <= RST_SIGN_EXT;
      test_result_flag <= RST_TEST;
      general_output_flag <= RST_GEN_OUT;
    end else begin
      latched_arith_excess_flag <= next_excess;
      saturate_select <= next_saturate;
      product_scale_select <= next_scale;
      sign_extend_select <= next_sign_ext;
      test_result_flag <= next_test;
      general_output_flag <= next_gen_out;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_excess_sticky;
    @(posedge ref_clk) disable iff (reset)
      arith_excess |=> latched_arith_excess_flag;
  endproperty
  a_excess_sticky: assert property (p_excess_sticky) else $error("excess flag not set");

  property p_excess_hold;
    @(posedge ref_clk) disable iff (reset)
      latched_arith_excess_flag && !load_status_op && !conditional_branch_op |=> latched_arith_excess_flag;
  endproperty
  a_excess_hold: assert property (p_excess_hold) else $error("excess flag lost");

  property p_saturate_limit;
    @(posedge ref_clk) disable iff (reset)
      arith_excess && saturate_select |=> (acc_result == POS_LIMIT || acc_result == NEG_LIMIT);
  endproperty
  a_saturate_limit: assert property (p_saturate_limit) else $error("saturation limit wrong");

  property p_scale_only_by_ops;
    @(posedge ref_clk) disable iff (reset)
      !set_product_scale_op && !load_status_op |=> $stable(product_scale_select);
  endproperty
  a_scale_only_by_ops: assert property (p_scale_only_by_ops) else $error("scale select changed");

  property p_store_scaled;
    @(posedge ref_clk) disable iff (reset)
      store_product_lower && !store_product_upper |=> store_data == $past(scaled_product[DATA_W-1:0]);
  endproperty
  a_store_scaled: assert property (p_store_scaled) else $error("store bypassed shifter");

  property p_unsigned_mult;
    @(posedge ref_clk) disable iff (reset)
      mult_op == MSD_OP_UNSIGNED_MULTIPLY_OP |=> product_reg == PROD_W'($past(mult_operand_reg) * $past(data_bus));
  endproperty
  a_unsigned_mult: assert property (p_unsigned_mult) else $error("unsigned product wrong");

  property p_no_logic_excess;
    @(posedge ref_clk) disable iff (reset)
      alu_write && !alu_arith && !load_status_op && !latched_arith_excess_flag |=> !latched_arith_excess_flag;
  endproperty
  a_no_logic_excess: assert property (p_no_logic_excess) else $error("logical op overflowed");

  property p_imm_two_cycles;
    @(posedge ref_clk) disable iff (reset)
      mult_op == MSD_OP_MPY_IMM |=> !product_ready ##1 product_ready;
  endproperty
  a_imm_two_cycles: assert property (p_imm_two_cycles) else $error("immediate product timing");

  property p_unextended;
    @(posedge ref_clk) disable iff (reset)
      scale_in_req && add_unextended_op && scale_amt < MAX_SHIFT |=> !scaled_operand[PROD_W-1];
  endproperty
  a_unextended: assert property (p_unextended) else $error("unextended add extended");
endmodule : msd_datapath

// ---- tb/msd_mem_partner.sv ----
// Far-side data memory word that records the product stores.
// Assumes store_valid is a one-cycle pulse that qualifies store_data.
`timescale 1ns/10ps
module msd_mem_partner (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Store port
  input wire logic store_valid,
  input wire logic [msd_pkg::DATA_W-1:0] store_data,
  output logic [msd_pkg::DATA_W-1:0] stored_word
);
  // The word only changes on a qualified store, so a stray value on store_data shows as a miss
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stored_word <= 16'h0;
    end else if (store_valid) begin
      stored_word <= store_data;
    end
  end
endmodule : msd_mem_partner

// ---- tb/msd_datapath_test.sv ----
// Self-checking bench for the multiplier, shifter and status slice.
// Assumes msd_pkg, msd_datapath and the memory partner are compiled first.
`timescale 1ns/10ps
module msd_datapath_test;
  import msd_pkg::*;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  msd_mop_t mult_op = MSD_OP_NONE;
  msd_bit_t flag_sel = MSD_BIT_OTHER;
  logic [15:0] data_bus, prog_bus, scale_in_data, status_word_one, store_data, mult_operand_out, stored_word;
  logic [12:0] imm_operand;
  logic [4:0] scale_in_const;
  logic [1:0] scale_value, acc_top_bits;
  logic [31:0] alu_a, alu_b, alu_logic_result, product_to_alu, scaled_operand, acc_result, product_out;
  logic scale_in_req, scale_by_operand, add_unextended_op, alu_write, alu_arith, alu_is_sub, set_flag_op;
  logic clear_flag_op, set_product_scale_op, load_status_op, conditional_branch_op, branch_tests_excess;
  logic indexed_position_test_op, tested_bit, aux_compare_op, aux_compare_true, exponent_align_op;
  logic store_product_upper, store_product_lower, acc_result_valid, store_valid, data_move_req, fetch_both_req;
  logic product_ready, latched_arith_excess_flag, saturate_select, sign_extend_select;
  logic test_result_flag, general_output_flag, ex;
  msd_alu_t product_alu_action;
  msd_scale_t product_scale_select;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h17934;

  msd_datapath dut (.ref_clk, .reset, .mult_op, .data_bus, .prog_bus, .imm_operand, .scale_in_req, .scale_in_data,
    .scale_in_const, .scale_by_operand, .add_unextended_op, .alu_write, .alu_arith, .alu_is_sub, .alu_a, .alu_b,
    .alu_logic_result, .set_flag_op, .clear_flag_op, .flag_sel, .set_product_scale_op, .scale_value,
    .load_status_op, .status_word_one, .conditional_branch_op, .branch_tests_excess, .indexed_position_test_op,
    .tested_bit, .aux_compare_op, .aux_compare_true, .exponent_align_op, .acc_top_bits, .store_product_upper,
    .store_product_lower, .product_to_alu, .product_alu_action, .scaled_operand, .acc_result, .acc_result_valid,
    .store_data, .store_valid, .data_move_req, .fetch_both_req, .product_ready, .mult_operand_out, .product_out,
    .latched_arith_excess_flag, .saturate_select, .product_scale_select, .sign_extend_select, .test_result_flag,
    .general_output_flag);
  msd_mem_partner mem (.ref_clk, .reset, .store_valid, .store_data, .stored_word);

  always #12.5 ref_clk = ~ref_clk;

  task automatic step();
    @(negedge ref_clk);
  endtask : step

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] sc(input logic [31:0] p, input logic [1:0] m);
    return m == 2'h0 ? p : m == 2'h1 ? p << 1 : m == 2'h2 ? p << 4 : {{6{p[31]}}, p[31:6]};
  endfunction : sc

  // An idle cycle first, so a strobe never drops and rises within one time step
  task automatic op(input msd_mop_t o, input logic [15:0] d);
    step();
    mult_op = o;
    data_bus = d;
    step();
    mult_op = MSD_OP_NONE;
  endtask : op

  task automatic flag(input logic s, input msd_bit_t b);
    step();
    set_flag_op = s;
    clear_flag_op = !s;
    flag_sel = b;
    step();
    set_flag_op = 1'h0;
    clear_flag_op = 1'h0;
  endtask : flag

  task automatic alu(input logic ar, input logic sb, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] s;
    logic ov;
    s = sb ? a - b : a + b;
    ov = ar && (a[31] != s[31]) && (sb ? a[31] != b[31] : a[31] == b[31]);
    step();
    {alu_arith, alu_is_sub, alu_write} = {ar, sb, 1'h1};
    {alu_a, alu_b, alu_logic_result} = {a, b, a ^ b};
    step();
    alu_write = 1'h0;
    if (!ar) s = a ^ b;
    else if (ov && saturate_select) s = a[31] ? NEG_LIMIT : POS_LIMIT;
    ex = ex | ov;
    chk("acc", s, acc_result);
    chk("acc valid", 32'h1, acc_result_valid);
    chk("excess", {31'h0, ex}, latched_arith_excess_flag);
  endtask : alu

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // About 150 cycles are needed; twenty times that means a hang
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end

  initial begin
    logic [31:0] p, x, y, e;
    msd_mop_t lv[4];
    msd_alu_t la[4];
    lv = '{MSD_OP_LOAD_MOVE_PROD, MSD_OP_LOAD_ADD_PROD, MSD_OP_LOAD_ADD_PROD_MOVE, MSD_OP_LOAD_SUB_PROD};
    la = '{MSD_ALU_LOAD, MSD_ALU_ADD, MSD_ALU_ADD, MSD_ALU_SUB};
    {data_bus, prog_bus, scale_in_data, status_word_one, imm_operand, scale_in_const, scale_value} = '0;
    {acc_top_bits, alu_a, alu_b, alu_logic_result, scale_in_req, scale_by_operand, add_unextended_op} = '0;
    {alu_write, alu_arith, alu_is_sub, set_flag_op, clear_flag_op, set_product_scale_op, load_status_op} = '0;
    {conditional_branch_op, branch_tests_excess, indexed_position_test_op, tested_bit, aux_compare_op} = '0;
    {aux_compare_true, exponent_align_op, store_product_upper, store_product_lower, ex} = '0;
    repeat (5) step();
    reset = 1'h0;
    chk("excess", 32'h0, latched_arith_excess_flag);
    chk("scale sel", 32'h0, product_scale_select);
    chk("sign sel", 32'h1, sign_extend_select);
    chk("gen out", 32'h1, general_output_flag);
    for (int i = 0; i < 8; i++) begin
      x = rnd();
      y = rnd();
      op(MSD_OP_LOAD_OPERAND, x[15:0]);
      op(MSD_OP_MPY, y[15:0]);
      p = $signed(x[15:0]) * $signed(y[15:0]);
      chk("product", p, product_out);
      chk("ready", 32'h1, product_ready);
      chk("operand", {16'h0, x[15:0]}, mult_operand_out);
      set_product_scale_op = 1'h1;
      scale_value = i[1:0];
      step();
      set_product_scale_op = 1'h0;
      // The new select reaches the registered product one cycle later
      step();
      e = sc(p, i[1:0]);
      chk("scale sel", {30'h0, i[1:0]}, product_scale_select);
      chk("to alu", e, product_to_alu);
      chk("product kept", p, product_out);
      {store_product_upper, store_product_lower} = {~i[0], i[0]};
      step();
      {store_product_upper, store_product_lower} = 2'h0;
      step();
      chk("stored", {16'h0, i[0] ? e[15:0] : e[31:16]}, stored_word);
    end
    for (int i = 0; i < 4; i++) begin
      op(lv[i], y[15:0]);
      chk("action", la[i], product_alu_action);
      chk("move", {31'h0, i == 2}, data_move_req);
      chk("old product", sc(p, 2'h3), product_to_alu);
    end
    x = rnd();
    op(MSD_OP_UNSIGNED_MULTIPLY_OP, x[15:0]);
    chk("unsigned", y[15:0] * x[15:0], product_out);
    op(MSD_OP_SQUARE_ADD, x[15:0]);
    chk("square", $signed(x[15:0]) * $signed(x[15:0]), product_out);
    prog_bus = y[15:0];
    op(MSD_OP_MAC, x[15:0]);
    chk("mac", $signed(x[15:0]) * $signed(y[15:0]), product_out);
    chk("fetch both", 32'h1, fetch_both_req);
    op(MSD_OP_MAC_SHIFT, x[15:0]);
    chk("sample move", 32'h1, data_move_req);
    op(MSD_OP_LOAD_OPERAND, x[15:0]);
    imm_operand = y[28:16];
    op(MSD_OP_MPY_IMM, 16'h0);
    chk("imm early", 32'h0, product_ready);
    step();
    chk("imm ready", 32'h1, product_ready);
    chk("imm", $signed(x[15:0]) * $signed(y[28:16]), product_out);
    for (int k = 0; k < 8; k++) begin
      y = rnd();
      flag(k[0], MSD_BIT_SIGN_EXT);
      chk("sign sel", {31'h0, k[0]}, sign_extend_select);
      {scale_in_data, scale_in_const, scale_by_operand, add_unextended_op, scale_in_req} = {y[20:0], k[1], k[2], 1'h1};
      step();
      scale_in_req = 1'h0;
      e = (k[0] && !k[2]) ? {{16{y[20]}}, y[20:5]} : {16'h0, y[20:5]};
      e = e << (k[1] ? {1'h0, x[3:0]} : (y[4:0] > 5'h10 ? 5'h10 : y[4:0]));
      chk("scaled", e, scaled_operand);
    end
    for (int s = 0; s < 2; s++) begin
      flag(s[0], MSD_BIT_SATURATE);
      alu(1'h0, 1'h0, 32'hffffffff, 32'h7fffffff);
      alu(1'h1, 1'h0, 32'h7fffffff, 32'h1);
      alu(1'h1, 1'h1, 32'h80000000, 32'h1);
      alu(1'h1, 1'h0, 32'h1, 32'h2);
      {conditional_branch_op, branch_tests_excess} = 2'h3;
      step();
      {conditional_branch_op, branch_tests_excess, ex} = 3'h0;
      chk("excess clear", 32'h0, latched_arith_excess_flag);
    end
    for (int j = 0; j < 4; j++) begin
      step();
      {indexed_position_test_op, aux_compare_op, exponent_align_op} = {j == 0, j == 2, j[0]};
      {tested_bit, aux_compare_true, acc_top_bits} = {2'h3, j == 1 ? 2'h3 : 2'h2};
      step();
      {indexed_position_test_op, aux_compare_op, exponent_align_op} = 3'h0;
      chk("test flag", {31'h0, j != 1}, test_result_flag);
    end
    flag(1'h0, MSD_BIT_GEN_OUT);
    chk("gen out", 32'h0, general_output_flag);
    flag(1'h1, MSD_BIT_GEN_OUT);
    chk("gen out", 32'h1, general_output_flag);
    {status_word_one, load_status_op} = {16'h0c03, 1'h1};
    step();
    load_status_op = 1'h0;
    chk("saturate", 32'h1, saturate_select);
    chk("sign sel", 32'h0, sign_extend_select);
    chk("scale sel", 32'h3, product_scale_select);
    reset = 1'h1;
    step();
    reset = 1'h0;
    chk("scale sel", 32'h0, product_scale_select);
    chk("sign sel", 32'h1, sign_extend_select);
    chk("gen out", 32'h1, general_output_flag);
    wrap_up();
  end
endmodule : msd_datapath_test
